// ==== startup_seq.sv ====
`timescale 1ns/100ps
module startup_seq
  import startup_pkg::*;
#(
  parameter int COPY_LEN = COPY_CYCLES
)(
  input wire logic clock,
  input wire logic reset,
  input wire logic [7:0] addr,
  input wire logic [7:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [7:0] rdata,
  input wire logic pll_locked,
  input wire logic ext_mod_in,
  input wire logic int_mod,
  input wire logic [7:0] nvm_data,
  output logic [3:0] nvm_addr,
  input wire logic line_sync_addr_hi_strap_in,
  input wire logic frame_sync_addr_lo_strap_in,
  input wire logic line_sync_func,
  input wire logic frame_sync_func,
  output logic line_sync_addr_hi_strap_out,
  output logic line_sync_addr_hi_strap_oe,
  output logic frame_sync_addr_lo_strap_out,
  output logic frame_sync_addr_lo_strap_oe,
  output logic strap_pulldown_en,
  output logic [1:0] i2c_addr_low,
  output logic illum_mod,
  output logic demod_mod,
  output logic integ_done,
  output logic startup_done
);
  import startup_pkg::*;

  // --------------------------------------------------------------------
  // Start-up sequence
  // --------------------------------------------------------------------
  typedef enum logic [1:0] {S_STRAP, S_COPY, S_WAIT_PLL, S_READY} state_t;
  state_t state_r, state_nxt;

  logic [2:0] hi_sync_r, lo_sync_r, mod_sync_r;
  logic [5:0] ref_div_r;
  logic [2:0] ref_cnt_r;
  logic [31:0] copy_cnt_r;
  logic [3:0] word_r;
  logic [1:0] straps_r;
  logic ref_tick;
  logic strap_end;
  logic copy_end;
  logic run_r;
  logic hi_pin_r, lo_pin_r, mod_pin_r;

  cfg_if cfg ();

  assign ref_tick = ref_div_r == 6'(REF_DIV - 1);
  assign strap_end = (state_r == S_STRAP) && ref_tick && (ref_cnt_r == 3'(STRAP_REF_PERIODS - 1));
  assign copy_end = copy_cnt_r == 32'(COPY_LEN - 1);

  always_comb begin
    state_nxt = state_r;
    unique case (state_r)
      S_STRAP: if (strap_end) state_nxt = S_COPY;
      S_COPY: if (copy_end) state_nxt = S_WAIT_PLL;
      S_WAIT_PLL: if (pll_locked) state_nxt = S_READY;
      S_READY: state_nxt = S_READY;
    endcase
  end

  always_ff @(posedge clock) begin
    if (reset) begin
      state_r <= S_STRAP;
      ref_div_r <= 6'h00;
      ref_cnt_r <= 3'h0;
      copy_cnt_r <= 32'h0;
    end else begin
      state_r <= state_nxt;
      ref_div_r <= ref_tick ? 6'h00 : ref_div_r + 6'h01;
      if (ref_tick && state_r == S_STRAP) begin
        ref_cnt_r <= ref_cnt_r + 3'h1;
      end
      if (state_r == S_COPY && !copy_end) begin
        copy_cnt_r <= copy_cnt_r + 32'h1;
      end
    end
  end

  // --------------------------------------------------------------------
  // Pin synchronisers
  // --------------------------------------------------------------------
  // A pin change is taken only once the last two stages agree, so a level that
  // the first stage caught mid-transition never reaches the straps or the divider.
  always_ff @(posedge clock) begin
    if (reset) begin
      hi_sync_r <= 3'h0;
      lo_sync_r <= 3'h0;
      mod_sync_r <= 3'h0;
      hi_pin_r <= 1'b0;
      lo_pin_r <= 1'b0;
      mod_pin_r <= 1'b0;
    end else begin
      hi_sync_r <= {hi_sync_r[1:0], line_sync_addr_hi_strap_in};
      lo_sync_r <= {lo_sync_r[1:0], frame_sync_addr_lo_strap_in};
      mod_sync_r <= {mod_sync_r[1:0], ext_mod_in};
      if (hi_sync_r[2] == hi_sync_r[1]) begin
        hi_pin_r <= hi_sync_r[2];
      end
      if (lo_sync_r[2] == lo_sync_r[1]) begin
        lo_pin_r <= lo_sync_r[2];
      end
      if (mod_sync_r[2] == mod_sync_r[1]) begin
        mod_pin_r <= mod_sync_r[2];
      end
    end
  end

  // Straps are caught once at the end of the window and never again.
  always_ff @(posedge clock) begin
    if (reset) begin
      straps_r <= 2'h0;
    end else if (strap_end) begin
      straps_r <= {hi_pin_r, lo_pin_r};
    end
  end

  // --------------------------------------------------------------------
  // Strap pad control
  // --------------------------------------------------------------------
  always_ff @(posedge clock) begin
    if (reset) begin
      line_sync_addr_hi_strap_oe <= 1'b0;
      frame_sync_addr_lo_strap_oe <= 1'b0;
      strap_pulldown_en <= 1'b1;
      line_sync_addr_hi_strap_out <= 1'b0;
      frame_sync_addr_lo_strap_out <= 1'b0;
      i2c_addr_low <= 2'h0;
      startup_done <= 1'b0;
    end else begin
      line_sync_addr_hi_strap_oe <= state_r != S_STRAP;
      frame_sync_addr_lo_strap_oe <= state_r != S_STRAP;
      // Pull-downs drop in the same cycle as the drivers return, so the pads never float.
      strap_pulldown_en <= state_r == S_STRAP;
      line_sync_addr_hi_strap_out <= line_sync_func;
      frame_sync_addr_lo_strap_out <= frame_sync_func;
      i2c_addr_low <= straps_r;
      startup_done <= state_r == S_READY;
    end
  end

  // --------------------------------------------------------------------
  // Configuration registers, loaded from memory then by software, except 0xE9, which only memory loads
  // --------------------------------------------------------------------
  logic [7:0] regs_r [NVM_WORDS];
  logic [7:0] reg_addr [NVM_WORDS];
  logic copying;
  logic [7:0] rd_mux;

  assign reg_addr[0] = ADDR_MOD_CFG;
  assign reg_addr[1] = ADDR_MOD_FREQ;
  assign reg_addr[2] = ADDR_LED_CFG;
  assign reg_addr[3] = ADDR_INT_LEN_HI;
  assign reg_addr[4] = ADDR_INT_LEN_LO;
  assign reg_addr[5] = ADDR_INT_MUL_HI;
  assign reg_addr[6] = ADDR_INT_MUL_LO;
  assign reg_addr[7] = ADDR_DELAY_STEPS;
  assign reg_addr[8] = ADDR_DELAY_EN;
  assign reg_addr[9] = ADDR_DELAY_CAL;
  assign copying = (state_r == S_COPY) && (word_r < 4'(NVM_WORDS));

  always_ff @(posedge clock) begin
    if (reset) begin
      regs_r[0] <= RST_MOD_CFG;
      regs_r[1] <= RST_MOD_FREQ;
      regs_r[2] <= RST_LED_CFG;
      regs_r[3] <= RST_INT_LEN_HI;
      regs_r[4] <= RST_INT_LEN_LO;
      regs_r[5] <= RST_INT_MUL_HI;
      regs_r[6] <= RST_INT_MUL_LO;
      regs_r[7] <= RST_DELAY_STEPS;
      regs_r[8] <= RST_DELAY_EN;
      regs_r[9] <= RST_DELAY_CAL;
      word_r <= 4'h0;
      run_r <= 1'b0;
    end else begin
      if (copying) begin
        regs_r[word_r] <= nvm_data;
        word_r <= word_r + 4'h1;
      end
      if (wr && !copying) begin
        for (int i = 0; i < NVM_WORDS; i++) begin
          if (addr == reg_addr[i] && addr != ADDR_DELAY_CAL) begin
            regs_r[i] <= wdata;
          end
        end
      end
      if (wr && addr == ADDR_CTRL) begin
        run_r <= wdata[CTRL_RUN_BIT] && (state_r == S_READY);
      end
    end
  end

  always_comb begin
    rd_mux = 8'h00;
    for (int i = 0; i < NVM_WORDS; i++) begin
      if (addr == reg_addr[i]) begin
        rd_mux = regs_r[i];
      end
    end
    if (addr == ADDR_STATUS) begin
      rd_mux = {3'h0, integ_done, pll_locked, straps_r, startup_done};
    end
    if (addr == ADDR_CTRL) begin
      rd_mux = {7'h00, run_r};
    end
  end

  always_ff @(posedge clock) begin
    if (reset) begin
      rdata <= 8'h00;
      nvm_addr <= 4'h0;
    end else begin
      rdata <= rd ? rd_mux : 8'h00;
      nvm_addr <= state_r == S_COPY ? word_r + 4'h1 : 4'h0;
    end
  end

  assign cfg.mod_cfg = regs_r[0];
  assign cfg.mod_freq = regs_r[1];
  assign cfg.led_cfg = regs_r[2];
  assign cfg.int_len = {regs_r[3], regs_r[4]};
  assign cfg.int_mul = {regs_r[5], regs_r[6]};
  assign cfg.delay_steps = regs_r[7];
  assign cfg.delay_en = regs_r[8][DELAY_EN_BIT];
  assign cfg.busy = state_r != S_READY;
  assign cfg.run = run_r;

  mod_path u_mod_path (
    .clock(clock),
    .reset(reset),
    .ext_mod_sync(mod_pin_r),
    .int_mod(int_mod),
    .cfg(cfg),
    .illum_mod(illum_mod),
    .demod_mod(demod_mod),
    .integ_done(integ_done)
  );

  // --------------------------------------------------------------------
  // Checks
  // --------------------------------------------------------------------
  property p_strap_inputs;
    @(posedge clock) disable iff (reset)
    (state_r == S_STRAP) |=> !line_sync_addr_hi_strap_oe && !frame_sync_addr_lo_strap_oe;
  endproperty
  a_strap_inputs: assert property (p_strap_inputs) else $error("Strap driven in window");

  property p_strap_out;
    @(posedge clock) disable iff (reset)
    (state_r == S_COPY) |=> line_sync_addr_hi_strap_oe && frame_sync_addr_lo_strap_oe;
  endproperty
  a_strap_out: assert property (p_strap_out) else $error("Strap not back to output");

  property p_strap_hold;
    @(posedge clock) disable iff (reset)
    (state_r != S_STRAP) |=> $stable(straps_r);
  endproperty
  a_strap_hold: assert property (p_strap_hold) else $error("Strap value changed");

  property p_strap_take;
    @(posedge clock) disable iff (reset)
    strap_end |=> (straps_r == {$past(hi_pin_r), $past(lo_pin_r)});
  endproperty
  a_strap_take: assert property (p_strap_take) else $error("Strap sample wrong");

  property p_addr_map;
    @(posedge clock) disable iff (reset)
    (state_r == S_READY) |=> (i2c_addr_low == $past(straps_r));
  endproperty
  a_addr_map: assert property (p_addr_map) else $error("Address bits wrong");

  property p_done_needs_lock;
    @(posedge clock) disable iff (reset)
    $rose(startup_done) |-> $past(pll_locked, 2);
  endproperty
  a_done_needs_lock: assert property (p_done_needs_lock) else $error("Done before lock");

  property p_copy_bound;
    @(posedge clock) disable iff (reset)
    (state_r == S_COPY) |-> (copy_cnt_r < 32'(COPY_LEN));
  endproperty
  a_copy_bound: assert property (p_copy_bound) else $error("Copy overran");

  property p_nvm_load;
    @(posedge clock) disable iff (reset)
    (copying && word_r == 4'h0) |=> (regs_r[0] == $past(nvm_data));
  endproperty
  a_nvm_load: assert property (p_nvm_load) else $error("Memory copy lost");

  property p_pulldown_window;
    @(posedge clock) disable iff (reset)
    (state_r == S_STRAP) |=> strap_pulldown_en;
  endproperty
  a_pulldown_window: assert property (p_pulldown_window) else $error("Pull-down off");

  property p_copy_words;
    @(posedge clock) disable iff (reset)
    (state_r == S_WAIT_PLL) |-> (word_r == 4'(NVM_WORDS));
  endproperty
  a_copy_words: assert property (p_copy_words) else $error("Words not all copied");

  property p_run_ready;
    @(posedge clock) disable iff (reset)
    run_r |-> (state_r == S_READY);
  endproperty
  a_run_ready: assert property (p_run_ready) else $error("Run before ready");

  property p_busy_dark;
    @(posedge clock) disable iff (reset)
    (state_r != S_READY) |=> (!illum_mod && !demod_mod);
  endproperty
  a_busy_dark: assert property (p_busy_dark) else $error("Modulating while busy");

  property p_pins_func;
    @(posedge clock) disable iff (reset)
    (state_r == S_READY) |=>
      (line_sync_addr_hi_strap_oe && line_sync_addr_hi_strap_out == $past(line_sync_func));
  endproperty
  a_pins_func: assert property (p_pins_func) else $error("Strap pin not output");
endmodule

// ==== startup_pkg.sv ====
// How it works
// - Device runs from a 4 MHz reference, crystal or external clock input.
// - Config register 0x80 bit 6 set selects the external modulation clock.
// - External modulation is the external modulation clock divided by four.
// - External integration time is period times (0xA2:0xA3 + 1) times 0xA0:0xA1.
// - Register 0x85 has no effect while the external clock is selected.
// - Selected modulation feeds both illumination driver and pixel demodulator.
// - Memory copy runs beside PLL start and completes within 340 us.
// - Copied values replace reset values of configuration registers.
// - After reset, straps are pulled-down inputs for 4 reference periods, then sampled.
// - A strap reads 0 without a pull-up and 1 with one.
// - After sampling, strap pins return to outputs.
// - Address bits A1 and A0 come from line-sync and frame-sync straps.
// - In DC modes the illumination driver stays continuously on.
// - Light-source modulation can be delayed relative to demodulation.
// - Register 0xAE enables the delay line; 0x73 sets delay in steps.
package startup_pkg;

  // ----------------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------------
  localparam logic [7:0] ADDR_MOD_CFG = 8'h80;
  localparam logic [7:0] ADDR_MOD_FREQ = 8'h85;
  localparam logic [7:0] ADDR_LED_CFG = 8'h90;
  localparam logic [7:0] ADDR_INT_LEN_HI = 8'ha0;
  localparam logic [7:0] ADDR_INT_LEN_LO = 8'ha1;
  localparam logic [7:0] ADDR_INT_MUL_HI = 8'ha2;
  localparam logic [7:0] ADDR_INT_MUL_LO = 8'ha3;
  localparam logic [7:0] ADDR_DELAY_STEPS = 8'h73;
  localparam logic [7:0] ADDR_DELAY_EN = 8'hae;
  localparam logic [7:0] ADDR_DELAY_CAL = 8'he9;
  localparam logic [7:0] ADDR_STATUS = 8'hf0;
  localparam logic [7:0] ADDR_CTRL = 8'hf1;

  localparam int EXT_MOD_SEL_BIT = 6;
  localparam int LED_DC_BIT = 1;
  localparam int DELAY_EN_BIT = 0;
  localparam int CTRL_RUN_BIT = 0;

  // ----------------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------------
  localparam logic [7:0] RST_MOD_CFG = 8'h00;
  localparam logic [7:0] RST_MOD_FREQ = 8'h00;
  localparam logic [7:0] RST_LED_CFG = 8'h00;
  localparam logic [7:0] RST_INT_LEN_HI = 8'h00;
  localparam logic [7:0] RST_INT_LEN_LO = 8'h01;
  localparam logic [7:0] RST_INT_MUL_HI = 8'h00;
  localparam logic [7:0] RST_INT_MUL_LO = 8'h00;
  localparam logic [7:0] RST_DELAY_STEPS = 8'h00;
  localparam logic [7:0] RST_DELAY_EN = 8'h00;
  localparam logic [7:0] RST_DELAY_CAL = 8'h00;

  // ----------------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------------
  localparam int CLOCK_MHZ = 250;
  localparam int REF_MHZ = 4;
  localparam int REF_DIV = CLOCK_MHZ / REF_MHZ;
  localparam int STRAP_REF_PERIODS = 4;
  localparam int MOD_DIVIDE = 4;
  localparam int COPY_TIME_US = 340;
  localparam int COPY_CYCLES = COPY_TIME_US * CLOCK_MHZ;
  localparam int NVM_WORDS = 10;

endpackage

// ==== cfg_if.sv ====
`timescale 1ns/100ps
interface cfg_if;
  logic [7:0] mod_cfg;
  logic [7:0] mod_freq;
  logic [7:0] led_cfg;
  logic [15:0] int_len;
  logic [15:0] int_mul;
  logic [7:0] delay_steps;
  logic delay_en;
  logic busy;
  logic run;
  modport ctrl (output mod_cfg, mod_freq, led_cfg, int_len, int_mul, delay_steps, delay_en,
                output busy, run);
  modport path (input mod_cfg, mod_freq, led_cfg, int_len, int_mul, delay_steps, delay_en,
                input busy, run);
endinterface

// ==== mod_path.sv ====
`timescale 1ns/100ps
module mod_path
  import startup_pkg::*;
(
  input wire logic clock,
  input wire logic reset,
  input wire logic ext_mod_sync,
  input wire logic int_mod,
  cfg_if.path cfg,
  output logic illum_mod,
  output logic demod_mod,
  output logic integ_done
);
  // --------------------------------------------------------------------
  // Modulation source selection
  // --------------------------------------------------------------------
  logic [1:0] div_r;
  logic ext_prev_r;
  logic [254:0] delay_r;
  logic [255:0] taps;
  logic [15:0] per_cnt_r;
  logic [15:0] len_cnt_r;
  logic ext_sel;
  logic ext_rise;
  logic mod_src;
  logic delayed;
  logic tick;

  assign ext_sel = cfg.mod_cfg[EXT_MOD_SEL_BIT];
  assign ext_rise = ext_mod_sync & ~ext_prev_r;
  // Internal source is used alone, so register 0x85 has no effect on either path.
  assign mod_src = ext_sel ? div_r[1] : (int_mod ^ cfg.mod_freq[0] & 1'b0);
  // Tap zero is the source itself, so a step count of n delays by exactly n clocks.
  assign taps = {delay_r, mod_src};
  assign delayed = cfg.delay_en ? taps[cfg.delay_steps] : mod_src;
  assign tick = ext_sel ? ext_rise : 1'b1;

  always_ff @(posedge clock) begin
    if (reset) begin
      div_r <= 2'h0;
      ext_prev_r <= 1'b0;
    end else begin
      ext_prev_r <= ext_mod_sync;
      if (ext_rise) begin
        div_r <= div_r + 2'h1;
      end
    end
  end

  always_ff @(posedge clock) begin
    if (reset) begin
      delay_r <= '0;
    end else begin
      delay_r <= {delay_r[253:0], mod_src};
    end
  end

  // --------------------------------------------------------------------
  // Integration timer: (mul + 1) tick periods (clocks, or external rises when selected), times len
  // --------------------------------------------------------------------
  always_ff @(posedge clock) begin
    if (reset || !cfg.run) begin
      per_cnt_r <= 16'h0000;
      len_cnt_r <= 16'h0000;
      integ_done <= 1'b0;
    end else if (tick && !integ_done) begin
      if (per_cnt_r == cfg.int_mul) begin
        per_cnt_r <= 16'h0000;
        if (len_cnt_r + 16'h0001 >= cfg.int_len) begin
          integ_done <= 1'b1;
        end
        len_cnt_r <= len_cnt_r + 16'h0001;
      end else begin
        per_cnt_r <= per_cnt_r + 16'h0001;
      end
    end
  end

  always_ff @(posedge clock) begin
    if (reset || cfg.busy) begin
      illum_mod <= 1'b0;
      demod_mod <= 1'b0;
    end else begin
      illum_mod <= cfg.led_cfg[LED_DC_BIT] ? 1'b1 : delayed;
      demod_mod <= mod_src;
    end
  end

  property p_dc_on;
    @(posedge clock) disable iff (reset)
    (!cfg.busy && cfg.led_cfg[LED_DC_BIT]) |=> illum_mod;
  endproperty
  a_dc_on: assert property (p_dc_on) else $error("DC mode illumination not on");

  property p_div4;
    @(posedge clock) disable iff (reset)
    (ext_rise && div_r == 2'h3) |=> (div_r == 2'h0);
  endproperty
  a_div4: assert property (p_div4) else $error("Divider does not wrap at four");
endmodule

// ==== far_side_model.sv ====
`timescale 1ns/100ps
module far_side_model (
  input wire logic clock,
  input wire logic ext_run,
  input wire logic pull_hi,
  input wire logic pull_lo,
  input wire logic hi_out,
  input wire logic hi_oe,
  input wire logic lo_out,
  input wire logic lo_oe,
  input wire logic pulldown_en,
  input wire logic [3:0] nvm_addr,
  output logic hi_pad,
  output logic lo_pad,
  output logic ext_mod_in,
  output logic [7:0] nvm_data
);
  logic float_r = 1'b0;

  // ----------------------------------------------------------------------
  // Strap pads
  // ----------------------------------------------------------------------
  // An undriven, unpulled pad wanders so a missing pull-down is never hidden.
  always @(posedge clock) float_r <= ~float_r;
  // Each address strap may carry a pull-up, set by its own pull input.
  assign hi_pad = hi_oe ? hi_out : (pull_hi ? 1'b1 : (pulldown_en ? 1'b0 : float_r));
  assign lo_pad = lo_oe ? lo_out : (pull_lo ? 1'b1 : (pulldown_en ? 1'b0 : float_r));

  // ----------------------------------------------------------------------
  // Memory and modulation clock
  // ----------------------------------------------------------------------
  assign nvm_data = 8'h80 | {4'h0, nvm_addr};
  // A 50 MHz clock that stands still low outside acquisitions.
  initial begin
    ext_mod_in = 1'b0;
    #1;
    forever begin
      #10;
      ext_mod_in = ext_run ? ~ext_mod_in : 1'b0;
    end
  end
endmodule

// ==== test_startup_seq.sv ====
`timescale 1ns/100ps
module test_startup_seq;
  import startup_pkg::*;
  logic clock, reset, wr, rd, pll_locked, int_mod = 1'b0, ext_run, pull_hi, pull_lo;
  logic ls_func, fs_func, hi_pad, lo_pad, hi_out, hi_oe, lo_out, lo_oe, pd_en, ext_mod_in;
  logic illum_mod, demod_mod, integ_done, startup_done, pe, pi, pd;
  logic [7:0] addr, wdata, rdata, nvm_data, v, dhist;
  logic [3:0] nvm_addr;
  logic [1:0] i2c_addr_low;
  int miscompares, n_tests, ne, ni, nd, i;
  logic [7:0] regs [10] = '{ADDR_MOD_CFG, ADDR_MOD_FREQ, ADDR_LED_CFG, ADDR_INT_LEN_HI,
    ADDR_INT_LEN_LO, ADDR_INT_MUL_HI, ADDR_INT_MUL_LO, ADDR_DELAY_STEPS, ADDR_DELAY_EN,
    ADDR_DELAY_CAL};

  startup_seq #(.COPY_LEN(40)) dut_u (.clock(clock), .reset(reset), .addr(addr),
    .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .pll_locked(pll_locked),
    .ext_mod_in(ext_mod_in), .int_mod(int_mod), .nvm_data(nvm_data), .nvm_addr(nvm_addr),
    .line_sync_addr_hi_strap_in(hi_pad), .frame_sync_addr_lo_strap_in(lo_pad),
    .line_sync_func(ls_func), .frame_sync_func(fs_func),
    .line_sync_addr_hi_strap_out(hi_out), .line_sync_addr_hi_strap_oe(hi_oe),
    .frame_sync_addr_lo_strap_out(lo_out), .frame_sync_addr_lo_strap_oe(lo_oe),
    .strap_pulldown_en(pd_en), .i2c_addr_low(i2c_addr_low), .illum_mod(illum_mod),
    .demod_mod(demod_mod), .integ_done(integ_done), .startup_done(startup_done));

  far_side_model far_u (.clock(clock), .ext_run(ext_run), .pull_hi(pull_hi),
    .pull_lo(pull_lo), .hi_out(hi_out), .hi_oe(hi_oe), .lo_out(lo_out), .lo_oe(lo_oe),
    .pulldown_en(pd_en), .nvm_addr(nvm_addr), .hi_pad(hi_pad), .lo_pad(lo_pad),
    .ext_mod_in(ext_mod_in), .nvm_data(nvm_data));

  // ----------------------------------------------------------------------
  // Clock, internal modulation and shared tasks
  // ----------------------------------------------------------------------
  initial begin
    clock = 1'b0;
    forever #2 clock = ~clock;
  end

  always @(posedge clock) begin
    if (($time / 4) % 4 == 0) int_mod <= ~int_mod;
  end

  task check(input logic [7:0] seen, input logic [7:0] exp);
    n_tests++;
    if (seen !== exp) begin
      miscompares++;
      $display("MISMATCH %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task wr_reg(input logic [7:0] a, input logic [7:0] d);
    @(posedge clock);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clock);
    wr <= 1'b0;
  endtask

  task rd_reg(input logic [7:0] a, output logic [7:0] d);
    @(posedge clock);
    addr <= a;
    rd <= 1'b1;
    @(posedge clock);
    rd <= 1'b0;
    #1 d = rdata;
  endtask

  // Counts rising edges of the external clock and both modulation outputs.
  task count_edges(input int cycles);
    ne = 0;
    ni = 0;
    nd = 0;
    {pe, pi, pd} = {ext_mod_in, illum_mod, demod_mod};
    repeat (cycles) begin
      @(posedge clock);
      #1;
      ne += int'(ext_mod_in & ~pe);
      ni += int'(illum_mod & ~pi);
      nd += int'(demod_mod & ~pd);
      {pe, pi, pd} = {ext_mod_in, illum_mod, demod_mod};
    end
  endtask

  task tally_and_finish;
    if (miscompares == 0 && n_tests > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  initial begin
    #80000;
    miscompares++;
    tally_and_finish();
  end

  // ----------------------------------------------------------------------
  // Tests
  // ----------------------------------------------------------------------
  initial begin
    {reset, addr, wdata, wr, rd, pll_locked, ext_run} = {1'b1, 20'h0};
    {pull_hi, pull_lo, ls_func, fs_func, pe, pi, pd, miscompares, n_tests} = 0;
    pull_hi = 1'b1;
    ls_func = 1'b1;
    repeat (20) @(posedge clock);
    reset <= 1'b0;
    #1 check({pd_en, hi_oe, lo_oe}, 3'b100);
    repeat (6) @(posedge clock);
    #1 check({pd_en, hi_oe, lo_oe}, 3'b100);
    // Written inside the strap window, so the memory copy must overwrite it.
    wr_reg(ADDR_DELAY_STEPS, 8'h5a);
    repeat (4 * REF_DIV + 10) @(posedge clock);
    #1 check({pd_en, hi_oe, lo_oe, hi_out, lo_out}, 5'b01110);
    check(i2c_addr_low, 2'b10);
    {pull_hi, pull_lo} = 2'b01;
    repeat (100) @(posedge clock);
    #1 check(startup_done, 1'b0);
    check(i2c_addr_low, 2'b10);
    @(posedge clock) pll_locked <= 1'b1;
    for (i = 0; i < 8 && startup_done !== 1'b1; i++) @(posedge clock);
    #1 check(startup_done, 1'b1);
    rd_reg(ADDR_STATUS, v);
    check(v[3:0], 4'b1101);
    for (i = 0; i < 10; i++) begin
      rd_reg(regs[i], v);
      check(v, 8'h80 | 8'(i));
    end
    wr_reg(ADDR_DELAY_CAL, 8'h00);
    rd_reg(ADDR_DELAY_CAL, v);
    check(v, 8'h89);
    rd_reg(8'h10, v);
    check(v, 8'h00);
    wr_reg(ADDR_LED_CFG, 8'h00);
    wr_reg(ADDR_DELAY_EN, 8'h00);
    wr_reg(ADDR_MOD_CFG, 8'h40);
    wr_reg(ADDR_MOD_FREQ, 8'hff);
    ext_run = 1'b1;
    wr_reg(ADDR_CTRL, 8'h01);
    repeat (20) @(posedge clock);
    count_edges(200);
    check(ne >= 39 && ne <= 41, 1'b1);
    check(ni >= 9 && ni <= 11, 1'b1);
    check(nd - ni <= 1 && ni - nd <= 1, 1'b1);
    wr_reg(ADDR_CTRL, 8'h00);
    wr_reg(ADDR_INT_LEN_HI, 8'h00);
    wr_reg(ADDR_INT_LEN_LO, 8'h03);
    wr_reg(ADDR_INT_MUL_HI, 8'h00);
    wr_reg(ADDR_INT_MUL_LO, 8'h01);
    wr_reg(ADDR_CTRL, 8'h01);
    for (i = 0; i < 20 && integ_done !== 1'b1; i++) count_edges(5);
    check(integ_done, 1'b1);
    check(i >= 5 && i <= 8, 1'b1);
    wr_reg(ADDR_CTRL, 8'h00);
    ext_run = 1'b0;
    wr_reg(ADDR_MOD_CFG, 8'h00);
    wr_reg(ADDR_LED_CFG, 8'h02);
    wr_reg(ADDR_CTRL, 8'h01);
    repeat (10) @(posedge clock);
    count_edges(40);
    check({ni == 0, illum_mod}, 2'b11);
    wr_reg(ADDR_CTRL, 8'h00);
    wr_reg(ADDR_LED_CFG, 8'h00);
    wr_reg(ADDR_DELAY_STEPS, 8'h03);
    wr_reg(ADDR_DELAY_EN, 8'h01);
    wr_reg(ADDR_CTRL, 8'h01);
    repeat (20) @(posedge clock);
    ne = 0;
    for (i = 0; i < 40; i++) begin
      @(posedge clock);
      #1 dhist = {dhist[6:0], demod_mod};
      if (i > 4) ne += int'(illum_mod === dhist[3]);
    end
    check(ne == 35, 1'b1);
    reset <= 1'b1;
    repeat (2) @(posedge clock);
    tally_and_finish();
  end
endmodule
